// *** src/dcr_pkg.sv ***
package dcr_pkg;
  // ==========================================
  // Register indices
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_BUS_ADDRESS = 8'h01;
  localparam logic [7:0] ADDR_OUT_FEATURES = 8'h02;
  // ==========================================
  // Field positions
  localparam int CFG_SPREAD_RANGE_BIT = 7;
  localparam int CFG_LANE_MAP_BIT = 6;
  localparam int CFG_MODE_HI = 3;
  localparam int CFG_MODE_LO = 2;
  localparam int CFG_SLEEP_BIT = 1;
  localparam int CFG_REG_CONTROL_BIT = 0;
  localparam int ADR_SOURCE_BIT = 7;
  localparam int ADR_FIELD_HI = 6;
  localparam int FEAT_DRIVE_EN_BIT = 7;
  localparam int FEAT_IDLE_SEL_BIT = 6;
  localparam int FEAT_SWING_BIT = 3;
  localparam int FEAT_OSC_HI = 2;
  // ==========================================
  // Reset values and writable masks
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] BUS_ADDRESS_RESET = 8'h70;
  localparam logic [7:0] OUT_FEATURES_RESET = 8'h00;
  localparam logic [7:0] CONFIG_MASK = 8'hCF;
  localparam logic [7:0] BUS_ADDRESS_MASK = 8'hFF;
  localparam logic [7:0] OUT_FEATURES_MASK = 8'hCF;
  // ==========================================
  // Operating modes
  typedef enum logic [1:0]
  {
    MODE_NORMAL = 2'h0,
    MODE_NORMAL_FILTER = 2'h1,
    MODE_LEGACY_GEN2 = 2'h2,
    MODE_LEGACY_GEN1 = 2'h3
  } dcr_mode_type;
  // Oscillator code "reserved"
  localparam logic [2:0] OSC_RESERVED = 3'h1;
  localparam logic [2:0] OSC_OFF = 3'h0;
  // Accepted bus addresses; any other value is stored but flagged invalid
  localparam int NUM_VALID_ADDR = 4;
  localparam logic [6:0] VALID_BUS_ADDR [NUM_VALID_ADDR] =
    '{7'h71, 7'h72, 7'h73, 7'h76};
endpackage

// *** src/dcr_regs.sv ***
// Function
// (RULE1) Config bit 7 picks spread range: 0 is 20-65 MHz, 1 is 10-20 MHz.
// (RULE2) Config bit 6 picks lane map: 0 LSBs, 1 MSBs on fourth lane.
// (RULE3) Config bits 3:2 pick mode: filter off, filter on, gen2, gen1.
// (RULE4) Config bit 1 sets sleep, keeping all register contents.
// (RULE5) Config bit 0 takes settings from registers instead of pins.
// (RULE6) Address bit 7 takes bus address from register, else strap pins.
// (RULE7) Address bits 6:0 hold bus address, reset 1110000; four values valid.
// (RULE8) Features bits 7 and 6: output enable and idle state, reset zero.
// (RULE9) Features bit 3 selects output swing: 0 low, 1 high.
// (RULE10) Features bits 2:0 pick internal oscillator; 000 off, 001 reserved.
module dcr_regs
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register access port from the serial bus engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Pin-strapped configuration (asynchronous pins)
  input wire logic [6:0] bus_address_strap,
  input wire logic pin_spread_range,
  input wire logic pin_lane_map,
  input wire logic [1:0] pin_mode,
  input wire logic pin_swing,
  input wire logic pin_drive_enable,
  input wire logic pin_idle_state,
  // Resolved configuration
  output logic low_freq_spread_range,
  output logic lane_map_select,
  output logic [1:0] op_mode,
  output logic sleep_active,
  output logic [6:0] bus_address,
  output logic bus_address_valid,
  output logic output_drive_enable,
  output logic output_idle_state_select,
  output logic swing_level_select,
  output logic [2:0] internal_oscillator_select,
  output logic oscillator_code_reserved
);

  // ==========================================
  // State
  typedef struct packed
  {
    logic [7:0] config_r;
    logic [7:0] addr_r;
    logic [7:0] feat_r;
    logic [7:0] rdata;
    logic [13:0] pin_s1;
    logic [13:0] pin_s2;
    logic spread;
    logic lane;
    logic [1:0] mode;
    logic sleep;
    logic [6:0] baddr;
    logic bvalid;
    logic drive;
    logic idle;
    logic swing;
    logic [2:0] osc;
    logic osc_rsv;
  } dcr_state_type;

  // ==========================================
  // Reset value
  // Synchronisers clear to zero, so pin-sourced settings need three edges
  // after release before they reflect the pins
  localparam dcr_state_type STATE_RESET = '{
    config_r: dcr_pkg::CONFIG_RESET,
    addr_r: dcr_pkg::BUS_ADDRESS_RESET, // [RULE7]
    feat_r: dcr_pkg::OUT_FEATURES_RESET, // [RULE8]
    rdata: 8'h00,
    pin_s1: 14'h0000,
    pin_s2: 14'h0000,
    spread: 1'b0,
    lane: 1'b0,
    mode: 2'h0,
    sleep: 1'b0,
    baddr: 7'h00,
    bvalid: 1'b0,
    drive: 1'b0,
    idle: 1'b0,
    swing: 1'b0,
    osc: 3'h0,
    osc_rsv: 1'b0
  };

  dcr_state_type state_reg;
  dcr_state_type state_next;
  logic [6:0] s_strap;
  logic s_spread;
  logic s_lane;
  logic [1:0] s_mode;
  logic s_swing;
  logic s_drive;
  logic s_idle;
  logic use_regs;
  logic [6:0] baddr_next;
  logic [dcr_pkg::NUM_VALID_ADDR-1:0] addr_hit;

  assign s_strap = state_reg.pin_s2[13:7];
  assign s_spread = state_reg.pin_s2[6];
  assign s_lane = state_reg.pin_s2[5];
  assign s_mode = state_reg.pin_s2[4:3];
  assign s_swing = state_reg.pin_s2[2];
  assign s_drive = state_reg.pin_s2[1];
  assign s_idle = state_reg.pin_s2[0];
  assign use_regs = state_reg.config_r[dcr_pkg::CFG_REG_CONTROL_BIT];

  // ==========================================
  // Bus address
  // The address source bit works even under pin control
  assign baddr_next = state_reg.addr_r[dcr_pkg::ADR_SOURCE_BIT] ? // [RULE6]
    state_reg.addr_r[dcr_pkg::ADR_FIELD_HI:0] : s_strap;

  // One comparator per accepted address; a miss only clears the flag
  for (genvar n = 0; n < dcr_pkg::NUM_VALID_ADDR; n++)
  begin : g_addr_hit
    assign addr_hit[n] = (baddr_next == dcr_pkg::VALID_BUS_ADDR[n]);
  end

  // ==========================================
  // Next state
  always_comb
  begin
    state_next = state_reg;
    // Pins are asynchronous: two flops before use
    // Straps are watched all the time, so a re-strap needs no reset
    state_next.pin_s1 = {bus_address_strap, pin_spread_range, pin_lane_map,
      pin_mode, pin_swing, pin_drive_enable, pin_idle_state};
    state_next.pin_s2 = state_reg.pin_s1;
    // Reserved bits are masked so they always read zero
    if (reg_wr)
    begin
      case (reg_addr)
        dcr_pkg::ADDR_CONFIG:
          state_next.config_r = reg_wdata & dcr_pkg::CONFIG_MASK;
        dcr_pkg::ADDR_BUS_ADDRESS:
          state_next.addr_r = reg_wdata & dcr_pkg::BUS_ADDRESS_MASK; // [RULE7]
        dcr_pkg::ADDR_OUT_FEATURES:
          state_next.feat_r = reg_wdata & dcr_pkg::OUT_FEATURES_MASK;
        // Writes to unmapped indices are dropped
        default:
          state_next.rdata = state_reg.rdata;
      endcase
    end
    // Read data is registered and holds until the next read
    if (reg_rd)
    begin
      case (reg_addr)
        dcr_pkg::ADDR_CONFIG:
          state_next.rdata = state_reg.config_r;
        dcr_pkg::ADDR_BUS_ADDRESS:
          state_next.rdata = state_reg.addr_r;
        dcr_pkg::ADDR_OUT_FEATURES:
          state_next.rdata = state_reg.feat_r;
        default:
          state_next.rdata = 8'h00;
      endcase
    end
    // Pins or registers supply the settings
    // Outputs are registered, so a change of source cannot glitch them
    if (use_regs) // [RULE5]
    begin
      state_next.spread =
        state_reg.config_r[dcr_pkg::CFG_SPREAD_RANGE_BIT]; // [RULE1]
      state_next.lane =
        state_reg.config_r[dcr_pkg::CFG_LANE_MAP_BIT]; // [RULE2]
      state_next.mode = state_reg.config_r[dcr_pkg::CFG_MODE_HI:
        dcr_pkg::CFG_MODE_LO]; // [RULE3]
      state_next.drive =
        state_reg.feat_r[dcr_pkg::FEAT_DRIVE_EN_BIT]; // [RULE8]
      state_next.idle =
        state_reg.feat_r[dcr_pkg::FEAT_IDLE_SEL_BIT]; // [RULE8]
      state_next.swing = state_reg.feat_r[dcr_pkg::FEAT_SWING_BIT]; // [RULE9]
      state_next.osc = state_reg.feat_r[dcr_pkg::FEAT_OSC_HI:0]; // [RULE10]
    end
    else
    begin
      state_next.spread = s_spread;
      state_next.lane = s_lane;
      state_next.mode = s_mode;
      state_next.drive = s_drive;
      state_next.idle = s_idle;
      state_next.swing = s_swing;
      // No oscillator pin exists, so pin control leaves it off
      state_next.osc = dcr_pkg::OSC_OFF;
    end
    // Sleep is register-only; contents are never touched by it
    state_next.sleep = state_reg.config_r[dcr_pkg::CFG_SLEEP_BIT]; // [RULE4]
    state_next.osc_rsv = (state_next.osc == dcr_pkg::OSC_RESERVED); // [RULE10]
    state_next.baddr = baddr_next;
    // A reserved address is still stored; only the flag marks it
    state_next.bvalid = |addr_hit; // [RULE7]
  end

  // ==========================================
  // Registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= STATE_RESET;
    else
      state_reg <= state_next;
  end

  // ==========================================
  // Outputs
  assign reg_rdata = state_reg.rdata;
  assign low_freq_spread_range = state_reg.spread;
  assign lane_map_select = state_reg.lane;
  assign op_mode = state_reg.mode;
  assign sleep_active = state_reg.sleep;
  assign bus_address = state_reg.baddr;
  assign bus_address_valid = state_reg.bvalid;
  assign output_drive_enable = state_reg.drive;
  assign output_idle_state_select = state_reg.idle;
  assign swing_level_select = state_reg.swing;
  assign internal_oscillator_select = state_reg.osc;
  assign oscillator_code_reserved = state_reg.osc_rsv;
endmodule

// *** verification/dcr_regs_props.sv ***
module dcr_regs_props
(
  // ====
  // Clock, reset and register port
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Resolved configuration
  input wire logic low_freq_spread_range,
  input wire logic lane_map_select,
  input wire logic [1:0] op_mode,
  input wire logic sleep_active,
  input wire logic [6:0] bus_address,
  input wire logic bus_address_valid,
  input wire logic [2:0] internal_oscillator_select,
  input wire logic oscillator_code_reserved,
  input wire logic output_drive_enable,
  input wire logic output_idle_state_select,
  input wire logic swing_level_select
);
  timeunit 1ns;
  timeprecision 1ns;
  logic reg_ctl;
  // Shadow of the register-control bit, rebuilt from observed writes
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_ctl <= 1'b0;
    else if (reg_wr && reg_addr == 8'h00)
      reg_ctl <= reg_wdata[0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // A lone write reaches the outputs two edges later
  a_spread_from_reg: assert property (reg_wr && reg_addr == 8'h00 &&
    reg_wdata[0] ##1 !reg_wr |=>
    low_freq_spread_range == $past(reg_wdata[7], 2))
    else $error("spread range not from register");
  a_drive_from_reg: assert property (reg_ctl && reg_addr == 8'h02 &&
    reg_wr ##1 !reg_wr |=> output_drive_enable == $past(reg_wdata[7], 2))
    else $error("output enable not from register");
  a_idle_from_reg: assert property (reg_ctl && reg_addr == 8'h02 &&
    reg_wr ##1 !reg_wr |=> output_idle_state_select == $past(reg_wdata[6], 2))
    else $error("idle state select not from register");
  a_swing_from_reg: assert property (reg_ctl && reg_addr == 8'h02 &&
    reg_wr ##1 !reg_wr |=> swing_level_select == $past(reg_wdata[3], 2))
    else $error("swing select not from register");
  a_osc_from_reg: assert property (reg_ctl && reg_addr == 8'h02 &&
    reg_wr ##1 !reg_wr |=>
    internal_oscillator_select == $past(reg_wdata[2:0], 2))
    else $error("oscillator select not from register");
  a_osc_off_pins: assert property (!reg_ctl &&
    !(reg_wr && reg_addr == 8'h00) |=> internal_oscillator_select == 3'h0)
    else $error("oscillator not off under pin control");
  a_lane_from_reg: assert property (reg_wr && reg_addr == 8'h00 &&
    reg_wdata[0] ##1 !reg_wr |=> lane_map_select == $past(reg_wdata[6], 2))
    else $error("lane map not from register");
  a_mode_from_reg: assert property (reg_wr && reg_addr == 8'h00 &&
    reg_wdata[0] ##1 !reg_wr |=> op_mode == $past(reg_wdata[3:2], 2))
    else $error("mode not from register");
  a_sleep_follows: assert property (reg_wr && reg_addr == 8'h00
    ##1 !reg_wr |=> sleep_active == $past(reg_wdata[1], 2))
    else $error("sleep not from register");
  a_addr_from_reg: assert property (reg_wr && reg_addr == 8'h01 &&
    reg_wdata[7] ##1 !reg_wr |=> bus_address == $past(reg_wdata[6:0], 2))
    else $error("bus address not from register");
  a_addr_valid_set: assert property (bus_address_valid ==
    (bus_address inside {7'h71, 7'h72, 7'h73, 7'h76}))
    else $error("bus address validity wrong");
  a_osc_reserved_flag: assert property (oscillator_code_reserved ==
    (internal_oscillator_select == 3'h1)) else $error("osc flag wrong");
  a_unmapped_reads_zero: assert property (reg_rd && reg_addr > 8'h02
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind dcr_regs dcr_regs_props dcr_regs_props_i (.*);

// *** verification/dcr_host.sv ***
module dcr_host
(
  // ====
  // Register port, strobes change at the falling edge
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // Idle lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~v};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'b0, ~a};
    v = reg_rdata;
  endtask
endmodule

// *** verification/dcr_regs_tb.sv ***
module dcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr, reg_rd, pin_spread_range, pin_lane_map, pin_swing;
  logic pin_drive_enable, pin_idle_state, low_freq_spread_range;
  logic lane_map_select, sleep_active, bus_address_valid;
  logic output_drive_enable, output_idle_state_select;
  logic swing_level_select, oscillator_code_reserved;
  logic [1:0] pin_mode, op_mode;
  logic [2:0] internal_oscillator_select;
  logic [6:0] bus_address, bus_address_strap = 7'h76;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, w, g;
  logic [8:0] tbl [6] = '{9'h1F1, 9'h1F2, 9'h1F3, 9'h1F6, 9'h0F4, 9'h0FF};
  int err_count = 0;
  int total_checks = 0;
  always #50 sys_clk = ~sys_clk;
  dcr_host dcr_host_i (.*);
  dcr_regs dcr_regs_i (.*);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    dcr_host_i.rd(a, d);
    chk("reg_rdata", e, d);
  endtask
  task automatic t_reset();
    repeat (3) @(negedge sys_clk);
    rdchk(8'h00, 8'h00);
    rdchk(8'h01, 8'h70);
    rdchk(8'h02, 8'h00);
    chk("bus_address", 8'h76, 8'(bus_address));
  endtask
  task automatic t_pins(input logic p);
    {pin_spread_range, pin_lane_map, pin_mode, pin_swing} = {5{p}};
    {pin_drive_enable, pin_idle_state} = {2{p}};
    repeat (4) @(negedge sys_clk);
    g = {1'b0, low_freq_spread_range, lane_map_select, op_mode,
      swing_level_select, output_drive_enable, output_idle_state_select};
    chk("pin_config", {1'b0, {7{p}}}, g);
    chk("osc", 8'h00, 8'(internal_oscillator_select));
  endtask
  task automatic t_regs();
    for (int i = 0; i < 8; i++)
    begin
      w = {i[1], i[0], 2'b11, i[1:0], i[0], 1'b1};
      dcr_host_i.wr(8'h00, w);
      @(negedge sys_clk);
      g = {3'h0, low_freq_spread_range, lane_map_select, op_mode,
        sleep_active};
      chk("cfg_out", {3'h0, w[7:6], w[3:1]}, g);
      rdchk(8'h00, w & 8'hCF);
      w = {i[0], i[1], 2'b11, i[0], i[2:0]};
      dcr_host_i.wr(8'h02, w);
      @(negedge sys_clk);
      g = {2'h0, output_drive_enable, output_idle_state_select,
        swing_level_select, internal_oscillator_select};
      chk("features_out", {2'h0, w[7:6], w[3:0]}, g);
      chk("osc_rsv", 8'(i == 1), 8'(oscillator_code_reserved));
      rdchk(8'h02, w & 8'hCF);
    end
    foreach (tbl[k])
    begin
      dcr_host_i.wr(8'h01, tbl[k][7:0]);
      @(negedge sys_clk);
      chk("bus_address", {1'b0, tbl[k][6:0]}, 8'(bus_address));
      chk("addr_valid", 8'(tbl[k][8]), 8'(bus_address_valid));
      rdchk(8'h01, tbl[k][7:0]);
    end
    dcr_host_i.wr(8'h03, 8'hFF);
    rdchk(8'h03, 8'h00);
    // Clearing the control bit hands settings back to the pins
    dcr_host_i.wr(8'h00, 8'h00);
    t_pins(1'b1);
    chk("bus_address", 8'h7F, 8'(bus_address));
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    {pin_spread_range, pin_lane_map, pin_mode, pin_swing} = 5'h00;
    {pin_drive_enable, pin_idle_state} = 2'h0;
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    t_reset();
    t_pins(1'b0);
    t_pins(1'b1);
    t_regs();
    rstn = 1'b0;
    @(negedge sys_clk);
    rstn = 1'b1;
    t_reset();
    t_pins(1'b1);
    end_sim();
  end
  initial
  begin
    #400000;
    err_count++;
    end_sim();
  end
endmodule
